// ===== design/sdo_upload_pkg.sv
// shared constants and frame carriers for the service-data upload server
package sdo_upload_pkg;
   localparam logic [10:0] RX_ID_BASE = 11'h600;
   localparam logic [10:0] TX_ID_BASE = 11'h580;
   localparam logic [7:0] CMD_INIT_UPLOAD = 8'h40;
   localparam logic [7:0] CMD_EXP_1 = 8'h4f;
   localparam logic [7:0] CMD_EXP_2 = 8'h4b;
   localparam logic [7:0] CMD_EXP_3 = 8'h47;
   localparam logic [7:0] CMD_EXP_4 = 8'h43;
   localparam logic [7:0] CMD_SEG_INIT = 8'h41;
   localparam logic [7:0] CMD_SEG_REQ0 = 8'h60;
   localparam logic [7:0] CMD_SEG_REQ1 = 8'h70;
   localparam logic [7:0] CMD_ABORT = 8'h80;
   localparam int TOGGLE_BIT = 4;
   localparam int UNUSED_LSB = 1;
   localparam int LAST_BIT = 0;
   localparam logic [31:0] ERR_CMD_UNKNOWN = 32'h05040001;
   localparam logic [31:0] ERR_TOGGLE = 32'h05030000;
   localparam logic [31:0] ERR_NO_OBJECT = 32'h06020000;
   localparam logic [15:0] LEN_W = 16'h0010;
   localparam int SEG_BYTES = 7;
   localparam int BUF_DEPTH = 2;

   typedef struct packed {
      logic [10:0] id;
      logic [7:0][7:0] data;
   } frame_t;

   typedef struct packed {
      logic found;
      logic [15:0] length;
      logic [31:0] value;
   } od_answer_t;
endpackage

// ===== design/frame_buffer.sv
// two-entry frame buffer between the server and the transmitter
`timescale 1ns/1ps
module frame_buffer
   import sdo_upload_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire sdo_upload_pkg::frame_t in_frame,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output sdo_upload_pkg::frame_t out_frame
);
   frame_t mem_reg [BUF_DEPTH];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = count_reg != 2'h2;
   assign out_valid = count_reg != 2'h0;
   // read data come out of a register slot directly
   assign out_frame = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_frame;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ===== design/sdo_upload_server.sv
// service-data upload server: expedited and segmented reads with abort
`timescale 1ns/1ps
module sdo_upload_server
   import sdo_upload_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // station
   input wire logic [6:0] station_number,
   // received frame from the link controller
   input wire logic rx_valid,
   input wire sdo_upload_pkg::frame_t rx_frame,
   // object dictionary lookup, answered same cycle
   output logic [15:0] object_index,
   output logic [7:0] object_subindex,
   output logic [15:0] od_offset,
   input wire sdo_upload_pkg::od_answer_t od_answer,
   input wire logic [7:0][7:0] od_bytes,
   // transmit frame towards the link controller
   output logic tx_valid,
   input wire logic tx_ready,
   output sdo_upload_pkg::frame_t tx_frame,
   // status
   output logic busy,
   output logic abort_seen
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEG = 2'b01
   } state_t;

   state_t state_reg;
   logic toggle_reg;
   logic [15:0] index_reg;
   logic [7:0] subindex_reg;
   logic [15:0] offset_reg;
   logic [15:0] length_reg;
   logic abort_seen_reg;
   logic busy_reg;
   logic [15:0] object_index_reg;
   logic [7:0] object_subindex_reg;
   logic [15:0] od_offset_reg;

   frame_t reply;
   logic reply_valid;
   logic buf_ready;
   logic req_hit;
   logic lookup_new;
   logic [15:0] req_index;
   logic [7:0] req_subindex;
   logic [15:0] remaining;
   logic [2:0] seg_len;
   logic seg_last;
   frame_t buf_frame;
   logic buf_valid;

   // error reply carries the reason code
   function automatic frame_t abort_frame(input logic [6:0] st, input logic [15:0] idx,
                                          input logic [7:0] sub, input logic [31:0] code);
      frame_t f;
      f.id = TX_ID_BASE + {4'h0, st};
      f.data[0] = CMD_ABORT;
      f.data[1] = idx[7:0];
      f.data[2] = idx[15:8];
      f.data[3] = sub;
      f.data[4] = code[7:0];
      f.data[5] = code[15:8];
      f.data[6] = code[23:16];
      f.data[7] = code[31:24];
      return f;
   endfunction

   function automatic logic [7:0] exp_cmd(input logic [15:0] len);
      case (len[2:0])
         3'h1: exp_cmd = CMD_EXP_1;
         3'h2: exp_cmd = CMD_EXP_2;
         3'h3: exp_cmd = CMD_EXP_3;
         default: exp_cmd = CMD_EXP_4;
      endcase
   endfunction

   assign req_hit = rx_valid && (rx_frame.id == RX_ID_BASE + {4'h0, station_number});
   assign req_index = {rx_frame.data[2], rx_frame.data[1]};
   assign req_subindex = rx_frame.data[3];
   assign remaining = length_reg - offset_reg;
   assign seg_last = remaining <= 16'(SEG_BYTES);
   assign seg_len = seg_last ? remaining[2:0] : 3'(SEG_BYTES);

   // fresh init re-points lookup
   // a new initiation mid-transfer must not be answered from the old object
   assign lookup_new = req_hit && (state_reg == ST_IDLE || rx_frame.data[0] == CMD_INIT_UPLOAD);

   // dictionary address: index from request in idle, held object while segmenting
   // subindex forwarded to dictionary
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         object_index_reg <= 16'h0000;
         object_subindex_reg <= 8'h00;
         od_offset_reg <= 16'h0000;
      end else begin
         object_index_reg <= lookup_new ? req_index : index_reg;
         object_subindex_reg <= lookup_new ? req_subindex : subindex_reg;
         od_offset_reg <= offset_reg;
      end
   end
   assign object_index = object_index_reg;
   assign object_subindex = object_subindex_reg;
   assign od_offset = od_offset_reg;

   // the request is decoded one cycle after arrival so the lookup has settled
   logic pend_reg;
   frame_t pend_frame_reg;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pend_reg <= 1'b0;
         pend_frame_reg <= '0;
      end else begin
         pend_reg <= req_hit;
         if (req_hit) begin
            pend_frame_reg <= rx_frame;
         end
      end
   end

   // reply composition; a stalled buffer drops the request, the client retries
   always_comb begin
      reply = '0;
      reply_valid = 1'b0;
      reply.id = TX_ID_BASE + {4'h0, station_number};
      if (pend_reg && buf_ready) begin
         reply_valid = 1'b1;
         if (pend_frame_reg.data[0] == CMD_ABORT) begin
            reply_valid = 1'b0;
         end else if (pend_frame_reg.data[0] == CMD_INIT_UPLOAD) begin
            if (!od_answer.found) begin
               reply = abort_frame(station_number, object_index_reg,
                                   object_subindex_reg, ERR_NO_OBJECT);
            end else if (od_answer.length <= 16'h0004 && od_answer.length != 16'h0000) begin
               reply.data[0] = exp_cmd(od_answer.length);
               reply.data[1] = object_index_reg[7:0];
               reply.data[2] = object_index_reg[15:8];
               reply.data[3] = object_subindex_reg;
               reply.data[4] = od_answer.value[7:0];
               reply.data[5] = od_answer.length > 16'h0001 ? od_answer.value[15:8] : 8'h00;
               reply.data[6] = od_answer.length > 16'h0002 ? od_answer.value[23:16] : 8'h00;
               reply.data[7] = od_answer.length > 16'h0003 ? od_answer.value[31:24] : 8'h00;
            end else begin
               reply.data[0] = CMD_SEG_INIT;
               reply.data[1] = object_index_reg[7:0];
               reply.data[2] = object_index_reg[15:8];
               reply.data[3] = object_subindex_reg;
               reply.data[4] = od_answer.length[7:0];
               reply.data[5] = od_answer.length[15:8];
            end
         end else if ((pend_frame_reg.data[0] & 8'hef) == CMD_SEG_REQ0) begin
            if (state_reg != ST_SEG) begin
               reply = abort_frame(station_number, pend_frame_reg.data[2:1],
                                   pend_frame_reg.data[3], ERR_CMD_UNKNOWN);
            end else if (pend_frame_reg.data[0][TOGGLE_BIT] != toggle_reg) begin
               reply = abort_frame(station_number, index_reg, subindex_reg, ERR_TOGGLE);
            end else begin
               reply.data[0][TOGGLE_BIT] = toggle_reg;
               reply.data[0][UNUSED_LSB +: 3] = 3'(SEG_BYTES) - seg_len;
               reply.data[0][LAST_BIT] = seg_last;
               for (int i = 1; i <= SEG_BYTES; i++) begin
                  reply.data[i] = (3'(i) <= seg_len) ? od_bytes[i - 1] : 8'h00;
               end
            end
         end else begin
            reply = abort_frame(station_number, pend_frame_reg.data[2:1],
                                pend_frame_reg.data[3], ERR_CMD_UNKNOWN);
         end
      end
   end

   // transfer state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         toggle_reg <= 1'b0;
         index_reg <= 16'h0000;
         subindex_reg <= 8'h00;
         offset_reg <= 16'h0000;
         length_reg <= 16'h0000;
      end else if (pend_reg && pend_frame_reg.data[0] == CMD_ABORT) begin
         state_reg <= ST_IDLE;
      end else if (reply_valid) begin
         if (reply.data[0] == CMD_SEG_INIT) begin
            state_reg <= ST_SEG;
            toggle_reg <= 1'b0;
            index_reg <= object_index_reg;
            subindex_reg <= object_subindex_reg;
            length_reg <= od_answer.length;
            offset_reg <= 16'h0000;
         end else if (reply.data[0] == CMD_ABORT) begin
            state_reg <= ST_IDLE;
         end else if (state_reg == ST_SEG && pend_frame_reg.data[0] != CMD_INIT_UPLOAD) begin
            toggle_reg <= ~toggle_reg;
            offset_reg <= offset_reg + {13'h0000, seg_len};
            if (seg_last) begin
               state_reg <= ST_IDLE;
            end
         end else begin
            state_reg <= ST_IDLE;
         end
      end
   end

   // status flags
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg <= 1'b0;
         abort_seen_reg <= 1'b0;
      end else begin
         busy_reg <= state_reg == ST_SEG;
         abort_seen_reg <= pend_reg && pend_frame_reg.data[0] == CMD_ABORT;
      end
   end
   assign busy = busy_reg;
   assign abort_seen = abort_seen_reg;

   frame_buffer u_buf (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .in_valid(reply_valid),
      .in_ready(buf_ready),
      .in_frame(reply),
      .out_valid(buf_valid),
      .out_ready(tx_ready),
      .out_frame(buf_frame)
   );
   assign tx_valid = buf_valid;
   assign tx_frame = buf_frame;

   property p_toggle_echo;
      @(posedge clk_sys) disable iff (!reset_n)
         (reply_valid && state_reg == ST_SEG && reply.data[0][7:5] == 3'h0)
         |-> reply.data[0][TOGGLE_BIT] == pend_frame_reg.data[0][TOGGLE_BIT];
   endproperty
   a_toggle_echo: assert property (p_toggle_echo) else $error("toggle not echoed");

   property p_exp_cmd;
      @(posedge clk_sys) disable iff (!reset_n)
         (reply_valid && reply.data[0] == CMD_EXP_2) |-> od_answer.length == 16'h0002;
   endproperty
   a_exp_cmd: assert property (p_exp_cmd) else $error("expedited length wrong");

   sequence s_last_seg;
      reply_valid && state_reg == ST_SEG && reply.data[0][7:5] == 3'h0 && seg_last;
   endsequence
   property p_idle_after_last;
      @(posedge clk_sys) disable iff (!reset_n) s_last_seg |=> state_reg == ST_IDLE;
   endproperty
   a_idle_after_last: assert property (p_idle_after_last) else $error("not idle");

   property p_toggle_start;
      @(posedge clk_sys) disable iff (!reset_n)
         (reply_valid && reply.data[0] == CMD_SEG_INIT) |=> !toggle_reg;
   endproperty
   a_toggle_start: assert property (p_toggle_start) else $error("toggle not zero");

   property p_abort_silent;
      @(posedge clk_sys) disable iff (!reset_n)
         (pend_reg && pend_frame_reg.data[0] == CMD_ABORT) |-> !reply_valid;
   endproperty
   a_abort_silent: assert property (p_abort_silent) else $error("abort answered");

   property p_missing;
      @(posedge clk_sys) disable iff (!reset_n)
         (reply_valid && pend_frame_reg.data[0] == CMD_INIT_UPLOAD && !od_answer.found)
         |-> reply.data[7:4] == ERR_NO_OBJECT;
   endproperty
   a_missing: assert property (p_missing) else $error("missing object code");

   property p_tx_id;
      @(posedge clk_sys) disable iff (!reset_n)
         reply_valid |-> reply.id == TX_ID_BASE + {4'h0, station_number};
   endproperty
   a_tx_id: assert property (p_tx_id) else $error("bad reply id");

   property p_idle_seg;
      @(posedge clk_sys) disable iff (!reset_n)
         (reply_valid && state_reg == ST_IDLE && pend_frame_reg.data[0] == CMD_SEG_REQ0)
         |-> reply.data[0] == CMD_ABORT;
   endproperty
   a_idle_seg: assert property (p_idle_seg) else $error("idle segment not aborted");
endmodule

// ===== bench/sdo_client_model.sv
// client node model: sends service-data requests and takes replies
`timescale 1ns/1ps
module sdo_client_model
   import sdo_upload_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // addressing
   input wire logic [6:0] station_number,
   // request path
   output logic rx_valid,
   output sdo_upload_pkg::frame_t rx_frame,
   // reply path
   input wire logic tx_valid,
   output logic tx_ready,
   input wire sdo_upload_pkg::frame_t tx_frame
);
   logic toggle;

   initial begin
      rx_valid = 1'b0;
      rx_frame = '0;
      tx_ready = 1'b0;
      toggle = 1'b0;
   end

   task automatic send(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] tail, input logic wrong_id);
      @(negedge clk_sys);
      rx_frame.id = RX_ID_BASE + {4'h0, station_number} + {10'h0, wrong_id};
      rx_frame.data = {tail, sub, idx, cmd};
      rx_valid = 1'b1;
      if (cmd == 8'h40 || cmd == 8'h80) toggle = 1'b0;
      @(negedge clk_sys);
      rx_valid = 1'b0;
      // released lines must not keep showing the last frame
      rx_frame = ~rx_frame;
   endtask

   task automatic seg(input logic [15:0] idx);
      send(toggle ? 8'h70 : 8'h60, idx, 8'h00, 32'h0, 1'b0);
      toggle = ~toggle;
   endtask

   task automatic recv(output sdo_upload_pkg::frame_t f, output logic got);
      got = 1'b0;
      f = '0;
      repeat (20) begin
         @(negedge clk_sys);
         if (tx_valid === 1'b1) break;
      end
      if (tx_valid === 1'b1) begin
         got = 1'b1;
         f = tx_frame;
         tx_ready = 1'b1;
         @(negedge clk_sys);
         tx_ready = 1'b0;
      end
   endtask
endmodule

// ===== bench/sdo_upload_server_tb.sv
// self-checking testbench for the service-data upload server
`timescale 1ns/1ps
module sdo_upload_server_tb;
   import sdo_upload_pkg::*;
   localparam logic [135:0] STR = "seg-read-testdata";
   localparam logic [31:0] VAL = 32'hd4c3b2a1;
   logic clk_sys;
   logic reset_n;
   logic [6:0] station_number;
   logic rx_valid;
   frame_t rx_frame;
   logic [15:0] object_index;
   logic [7:0] object_subindex;
   logic [15:0] od_offset;
   od_answer_t od_answer;
   logic [7:0][7:0] od_bytes;
   logic tx_valid;
   logic tx_ready;
   frame_t tx_frame;
   logic busy;
   logic abort_seen;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   int aborts = 0;
   int ab0;

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   sdo_upload_server DUT (.clk_sys(clk_sys), .reset_n(reset_n), .station_number(station_number),
      .rx_valid(rx_valid), .rx_frame(rx_frame), .object_index(object_index),
      .object_subindex(object_subindex), .od_offset(od_offset), .od_answer(od_answer),
      .od_bytes(od_bytes), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
      .busy(busy), .abort_seen(abort_seen));

   sdo_client_model client (.clk_sys(clk_sys), .station_number(station_number),
      .rx_valid(rx_valid),
      .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame));

   function automatic logic [7:0] sb(input int i);
      return STR[8 * (16 - i) +: 8];
   endfunction

   // dictionary stand-in; past the end of the string it answers zero
   always_comb begin
      od_answer = '0;
      for (int i = 0; i < 8; i++) begin
         od_bytes[i] = (i < 7 && int'(od_offset) + i < 17) ? sb(int'(od_offset) + i) : 8'h00;
      end
      if (object_index[15:2] == 14'h0800) begin
         od_answer = {1'b1, 16'(object_index[1:0]) + 16'h0001, VAL};
      end else if (object_index == 16'h100a) begin
         od_answer = {1'b1, 16'h0011, 32'h0};
      end else if (object_index == 16'h2100 && object_subindex != 8'h00) begin
         od_answer = {1'b1, 16'h0001, 24'h0, sb(int'(object_subindex) - 1)};
      end
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (abort_seen === 1'b1) aborts++;
      if (cycles == 4000) begin
         n_mismatch++;
         $display("ERROR t=%0t run did not complete", $time);
         final_report();
      end
   end

   task automatic check(input logic [74:0] seen, input logic [74:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic frame_t frm(input logic [63:0] d);
      frame_t f;
      f.id = TX_ID_BASE + {4'h0, station_number};
      f.data = d;
      return f;
   endfunction

   function automatic frame_t seg_frm(input int k, input logic t);
      int cnt;
      logic [63:0] d;
      cnt = (17 - 7 * k > 7) ? 7 : 17 - 7 * k;
      d = '0;
      for (int i = 0; i < cnt; i++) d[8 * (i + 1) +: 8] = sb(7 * k + i);
      d[7:0] = {3'b000, t, 3'(7 - cnt), k == 2};
      return frm(d);
   endfunction

   task automatic expect_frame(input frame_t e);
      frame_t f;
      logic got;
      client.recv(f, got);
      check(75'(got), 75'h1);
      check(f, e);
   endtask

   task automatic expect_none(input int n);
      repeat (n) @(negedge clk_sys);
      check(75'(tx_valid), 75'h0);
   endtask

   task automatic init_seg();
      client.send(8'h40, 16'h100a, 8'h00, 32'h0, 1'b0);
      expect_frame(frm({32'h11, 8'h00, 16'h100a, 8'h41}));
   endtask

   task automatic done(input string name);
      $display("test %s finished, mismatches so far %0d", name, n_mismatch);
   endtask

   initial begin
      reset_n = 1'b0;
      station_number = 7'h03;
      repeat (5) @(negedge clk_sys);
      reset_n = 1'b1;
      for (int l = 1; l <= 4; l++) begin
         client.send(8'h40, 16'h1fff + 16'(l), 8'h00, 32'h0, 1'b0);
         expect_frame(frm({VAL & (32'hffffffff >> (8 * (4 - l))), 8'h00, 16'h1fff + 16'(l),
                           8'h53 - 8'(4 * l)})); // length codes and padding
      end
      for (int s = 1; s <= 3; s++) begin
         client.send(8'h40, 16'h2100, 8'(s), 32'h0, 1'b0);
         expect_frame(frm({24'h0, sb(s - 1), 8'(s), 16'h2100, 8'h4f})); // per character
      end
      done("expedited");
      client.send(8'h40, 16'h3000, 8'h00, 32'h0, 1'b0);
      expect_frame(frm({32'h06020000, 8'h00, 16'h3000, 8'h80})); // missing object
      client.send(8'h5f, 16'h2000, 8'h00, 32'h0, 1'b0);
      expect_frame(frm({32'h05040001, 8'h00, 16'h2000, 8'h80})); // unknown command
      client.seg(16'h100a);
      expect_frame(frm({32'h05040001, 8'h00, 16'h100a, 8'h80})); // segment while idle
      client.send(8'h40, 16'h2000, 8'h00, 32'h0, 1'b1);
      expect_none(8); // foreign identifier ignored
      done("errors");
      init_seg(); // initiation with length
      check(75'(busy), 75'h1); // transfer open
      for (int k = 0; k < 3; k++) begin
         client.seg(16'h100a);
         expect_frame(seg_frm(k, k[0])); // segment fields
      end
      repeat (3) @(negedge clk_sys);
      check(75'(busy), 75'h0); // idle after last
      done("segmented");
      init_seg();
      client.seg(16'h100a);
      expect_frame(seg_frm(0, 1'b0));
      client.send(8'h60, 16'h100a, 8'h00, 32'h0, 1'b0);
      expect_frame(frm({32'h05030000, 8'h00, 16'h100a, 8'h80})); // toggle not changed
      done("toggle");
      init_seg();
      client.seg(16'h100a);
      expect_frame(seg_frm(0, 1'b0));
      ab0 = aborts;
      client.send(8'h80, 16'h100a, 8'h00, 32'hdeadbeef, 1'b0);
      expect_none(8); // abort not answered
      check(75'(aborts - ab0), 75'h1); // abort noticed once
      client.send(8'h70, 16'h100a, 8'h00, 32'h0, 1'b0);
      expect_frame(frm({32'h05040001, 8'h00, 16'h100a, 8'h80})); // only fresh initiation
      init_seg();
      client.seg(16'h100a);
      expect_frame(seg_frm(0, 1'b0)); // toggle back at zero
      done("abort");
      client.send(8'h40, 16'h2003, 8'h00, 32'h0, 1'b0);
      repeat (4) @(negedge clk_sys);
      client.send(8'h40, 16'h2001, 8'h00, 32'h0, 1'b0);
      repeat (4) @(negedge clk_sys);
      client.send(8'h40, 16'h2002, 8'h00, 32'h0, 1'b0);
      repeat (5) @(negedge clk_sys);
      check(75'(tx_valid), 75'h1); // reply held while stalled
      expect_frame(frm({VAL, 8'h00, 16'h2003, 8'h43})); // first held reply
      expect_frame(frm({16'h0, VAL[15:0], 8'h00, 16'h2001, 8'h4b})); // second held reply
      expect_none(6); // third request dropped when full
      done("stall");
      init_seg();
      client.send(8'h40, 16'h2001, 8'h00, 32'h0, 1'b0);
      expect_frame(frm({16'h0, VAL[15:0], 8'h00, 16'h2001, 8'h4b})); // init mid-transfer
      check(75'(busy), 75'h0); // old transfer replaced
      station_number = 7'h2a;
      client.send(8'h40, 16'h2000, 8'h00, 32'h0, 1'b0);
      expect_frame(frm({24'h0, VAL[7:0], 8'h00, 16'h2000, 8'h4f})); // id follows station
      done("reinit and station");
      final_report();
   end
endmodule
